//--- core/ssms_params.svh
// Constants of the shared static memory system.
// Assumes inclusion by ssms_pkg.sv and the design modules.
`ifndef SSMS_PARAMS_SVH
`define SSMS_PARAMS_SVH
`define SSMS_NPROC      4
`define SSMS_JC_INIT    2'h0
`define SSMS_TICK_W     9
`define SSMS_TICK_LAST  9'h1ff
`define SSMS_BANK_AW    8
`define SSMS_FIFO_W     16
`define SSMS_FIFO_DEPTH 32
`define SSMS_FIFO_AW    5
`define SSMS_LEN_W      3
`define SSMS_LEN_B1     3'h0
`define SSMS_LEN_B2     3'h1
`define SSMS_LEN_B4     3'h2
`define SSMS_LEN_B8     3'h3
`define SSMS_LEN_B10    3'h4
`define SSMS_CNT_1      3'h1
`define SSMS_CNT_2      3'h2
`define SSMS_CNT_4      3'h4
`define SSMS_CNT_5      3'h5
`define SSMS_GRANT_NONE 4'hf
`define SSMS_STEP       16'h0002
`endif

//--- core/ssms_pkg.sv
// Types shared by the memory system modules.
// Assumes ssms_params.svh is on the include path.
`include "ssms_params.svh"
package ssms_pkg;
  typedef enum logic [1:0] {
    S_IDLE   = 2'h0,
    S_ACCESS = 2'h1,
    S_DONE   = 2'h3,
    S_WAIT   = 2'h2
  } ssms_state_t;

  typedef struct packed {
    logic                   wr;
    logic [`SSMS_LEN_W-1:0] len;
    logic [15:0]            addr;
  } ssms_req_t;

  typedef struct packed {
    logic phase_first;
    logic phase_second;
    logic tick;
  } ssms_clk_t;
endpackage : ssms_pkg

//--- core/ssms_fifo.sv
// Read-data FIFO with registered output stage.
// Assumes one clock and a synchronised active-low reset.
`timescale 1ns/1ns
`include "ssms_params.svh"
module ssms_fifo #(
  parameter int W     = `SSMS_FIFO_W,
  parameter int DEPTH = `SSMS_FIFO_DEPTH,
  parameter int AW    = `SSMS_FIFO_AW
) (
  input  wire logic         clk_sys,    // System clock
  input  wire logic         rst_sync_n, // Synchronised reset
  input  wire logic         in_valid,   // Write strobe
  input  wire logic [W-1:0] in_data,    // Write word
  output logic              in_ready,   // Room left
  output logic              out_valid,  // Output word valid
  output logic [W-1:0]      out_data,   // Output word
  input  wire logic         out_ready   // Drain accepts
);
  import ssms_pkg::*;
  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0]   cnt_ff;
  logic          push;
  logic          pop;

  assign in_ready = (cnt_ff != (AW+1)'(DEPTH));
  assign push     = in_valid && in_ready;
  assign pop      = (cnt_ff != '0) && (!out_valid || out_ready);

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff    <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

  // Output stage keeps the drain side straight from flip-flops
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_data  <= mem[rd_ptr_ff];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end
endmodule : ssms_fifo

//--- core/ssms_top.sv
// Memory system: clock phases, timer tick, arbiter, byte-bank sequencer.
// Assumes request and write ports come from logic on clk_sys; request
// pins from the processors are asynchronous and synchronised here.
`timescale 1ns/1ns
`include "ssms_params.svh"
// Notes on behaviour
// - Both clock phases run at a quarter of clk_sys from a Johnson counter.
// - The phases are square waves, the second lagging by 90 degrees.
// - Timer tick is the first phase divided by 1024.
// - Address bit 0 low means aligned, high means unaligned.
// - Unaligned accesses swap lanes so data is right-justified.
// - Unaligned double byte uses two banks at consecutive locations.
// - Length code loads a recoded double-byte count.
// - Length code 0 raises the single-byte signal.
// - The counter counts double-byte accesses until the transfer ends.
// - Transfer end pulses; bus error status always reports no error.
// - Wait-insert pulses once per unaligned double byte.
// - Each wait-insert shows a wait on the granted interconnect status.
// - Aligned and single-byte accesses get no wait state.
// - Request four has highest priority, request one lowest.
// - Only the winning requester sees its low grant line.
// - Grant stays asserted for the whole access.
module ssms_top (
  input  wire logic                  clk_sys,            // 100 MHz clock
  input  wire logic                  rst_n,              // Async reset
  input  wire logic [3:0]            bus_request_n,      // Pin requests
  output logic [3:0]                 bus_grant_n,        // Grants
  output ssms_pkg::ssms_clk_t        clk_out,            // Phases, tick
  input  wire logic                  req_valid,          // Request strobe
  input  wire ssms_pkg::ssms_req_t   req,                // Request
  output logic                       req_ready,          // Request taken
  input  wire logic                  wdata_valid,        // Write word
  input  wire logic [15:0]           wdata,              // Write data
  output logic                       wdata_ready,        // Buffer free
  output logic                       rd_valid,           // Read word
  output logic [15:0]                rd_data,            // Read data
  input  wire logic                  rd_ready,           // Drain ready
  output logic [3:0]                 interconnect_status,// Wait per proc
  output logic                       bus_error_status,   // Always clear
  output logic                       transfer_end,       // End pulse
  output logic                       byte_access,        // Single byte
  output logic                       wait_insert         // Wait pulse
);
  import ssms_pkg::*;

  localparam int BN = 1 << `SSMS_BANK_AW;

  logic [1:0]               rst_sync_ff;
  logic                     rst_sync_n;
  logic [1:0]               jc_ff;
  logic [`SSMS_TICK_W-1:0]  tick_cnt_ff;
  logic [3:0]               req_meta_ff;
  logic [3:0]               req_sync_ff;
  logic [3:0]               nxt_grant_n;
  ssms_state_t              state_ff;
  ssms_state_t              nxt_state;
  logic [15:0]              addr_ff;
  logic [`SSMS_LEN_W-1:0]   cnt_ff;
  logic                     wr_ff;
  logic                     single_ff;
  logic [15:0]              wbuf_ff;
  logic                     wbuf_full;
  logic [7:0]               bank_even [BN];
  logic [7:0]               bank_odd  [BN];
  logic [`SSMS_BANK_AW-1:0] idx;
  logic [`SSMS_BANK_AW-1:0] idx_next;
  logic                     unaligned;
  logic                     take;
  logic                     go;
  logic                     xfer;
  logic [15:0]              rd_word;
  logic                     fifo_in_ready;

  function automatic logic [`SSMS_LEN_W-1:0] recode(
    input logic [`SSMS_LEN_W-1:0] len);
    case (len)
      `SSMS_LEN_B2:  recode = `SSMS_CNT_1;
      `SSMS_LEN_B4:  recode = `SSMS_CNT_2;
      `SSMS_LEN_B8:  recode = `SSMS_CNT_4;
      `SSMS_LEN_B10: recode = `SSMS_CNT_5;
      default:       recode = `SSMS_CNT_1;
    endcase
  endfunction : recode

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_sync_ff[1];

  // Johnson counter: 00,01,11,10 gives two quadrature bits
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      jc_ff <= `SSMS_JC_INIT;
    end else begin
      jc_ff <= {jc_ff[0], ~jc_ff[1]};
    end
  end

  // Tick toggles every 512 rising first-phase edges
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tick_cnt_ff <= '0;
      clk_out     <= '0;
    end else begin
      clk_out.phase_first  <= jc_ff[0];
      clk_out.phase_second <= jc_ff[1];
      if (jc_ff[0] && !clk_out.phase_first) begin
        tick_cnt_ff <= tick_cnt_ff + 1'b1;
        if (tick_cnt_ff == `SSMS_TICK_LAST) begin
          clk_out.tick <= ~clk_out.tick;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      req_meta_ff <= `SSMS_GRANT_NONE;
      req_sync_ff <= `SSMS_GRANT_NONE;
    end else begin
      req_meta_ff <= bus_request_n;
      req_sync_ff <= req_meta_ff;
    end
  end

  // Release needs both the request gone and the sequencer idle
  always_comb begin
    nxt_grant_n = bus_grant_n;
    if (bus_grant_n == `SSMS_GRANT_NONE) begin
      for (int i = 0; i < `SSMS_NPROC; i++) begin
        if (!req_sync_ff[i]) begin
          nxt_grant_n = ~(4'h1 << i);
        end
      end
    end else if ((req_sync_ff | bus_grant_n) != `SSMS_GRANT_NONE) begin
      nxt_grant_n = bus_grant_n;
    end else if (state_ff == S_IDLE) begin
      nxt_grant_n = `SSMS_GRANT_NONE;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      bus_grant_n <= `SSMS_GRANT_NONE;
    end else begin
      bus_grant_n <= nxt_grant_n;
    end
  end

  assign take      = (state_ff == S_IDLE) && req_valid && req_ready;
  assign unaligned = addr_ff[0] && !single_ff;
  assign go        = wr_ff ? wbuf_full : fifo_in_ready;
  assign xfer      = go && ((state_ff == S_WAIT) ||
                     (state_ff == S_ACCESS && !unaligned));
  assign idx       = addr_ff[`SSMS_BANK_AW:1];
  assign idx_next  = idx + 1'b1;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      S_IDLE: begin
        if (take) begin
          nxt_state = S_ACCESS;
        end
      end
      S_ACCESS: begin
        if (unaligned) begin
          nxt_state = S_WAIT;
        end else if (xfer && cnt_ff == `SSMS_CNT_1) begin
          nxt_state = S_DONE;
        end
      end
      S_WAIT: begin
        if (xfer) begin
          nxt_state = (cnt_ff == `SSMS_CNT_1) ? S_DONE : S_ACCESS;
        end
      end
      S_DONE: nxt_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_ff <= S_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Request register and double-byte counter
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      addr_ff   <= '0;
      cnt_ff    <= '0;
      wr_ff     <= 1'b0;
      single_ff <= 1'b0;
    end else if (take) begin
      addr_ff   <= req.addr;
      cnt_ff    <= recode(req.len);
      wr_ff     <= req.wr;
      single_ff <= (req.len == `SSMS_LEN_B1);
    end else if (xfer) begin
      addr_ff <= addr_ff + `SSMS_STEP;
      cnt_ff  <= cnt_ff - 1'b1;
    end
  end

  // Only one taken request may wait, so ready follows the next state
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      req_ready <= 1'b0;
    end else begin
      req_ready <= (nxt_state == S_IDLE) &&
                   (nxt_grant_n != `SSMS_GRANT_NONE);
    end
  end

  // One-word write buffer; ready is the flop itself, full its inverse
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wbuf_ff     <= '0;
      wdata_ready <= 1'b1;
    end else if (wdata_valid && wdata_ready) begin
      wbuf_ff     <= wdata;
      wdata_ready <= 1'b0;
    end else if (xfer && wr_ff) begin
      wdata_ready <= 1'b1;
    end
  end
  assign wbuf_full = !wdata_ready;

  // Banks: even bytes in one, odd bytes in the other
  always_ff @(posedge clk_sys) begin
    if (xfer && wr_ff) begin
      if (single_ff) begin
        if (addr_ff[0]) begin
          bank_odd[idx] <= wbuf_ff[7:0];
        end else begin
          bank_even[idx] <= wbuf_ff[7:0];
        end
      end else if (addr_ff[0]) begin
        bank_odd[idx]       <= wbuf_ff[7:0];
        bank_even[idx_next] <= wbuf_ff[15:8];
      end else begin
        bank_even[idx] <= wbuf_ff[7:0];
        bank_odd[idx]  <= wbuf_ff[15:8];
      end
    end
  end

  always_comb begin
    if (single_ff) begin
      rd_word = {8'h00, addr_ff[0] ? bank_odd[idx] : bank_even[idx]};
    end else if (addr_ff[0]) begin
      rd_word = {bank_even[idx_next], bank_odd[idx]};
    end else begin
      rd_word = {bank_odd[idx], bank_even[idx]};
    end
  end

  ssms_fifo #(
    .W     (`SSMS_FIFO_W),
    .DEPTH (`SSMS_FIFO_DEPTH),
    .AW    (`SSMS_FIFO_AW)
  ) u_rd_fifo (
    .clk_sys    (clk_sys),
    .rst_sync_n (rst_sync_n),
    .in_valid   (xfer && !wr_ff),
    .in_data    (rd_word),
    .in_ready   (fifo_in_ready),
    .out_valid  (rd_valid),
    .out_data   (rd_data),
    .out_ready  (rd_ready)
  );

  // Status outputs
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wait_insert         <= 1'b0;
      interconnect_status <= 4'h0;
      transfer_end        <= 1'b0;
      bus_error_status    <= 1'b0;
      byte_access         <= 1'b0;
    end else begin
      wait_insert <= (state_ff == S_ACCESS) && unaligned;
      interconnect_status <= (nxt_state == S_WAIT) ?
                             ~bus_grant_n : 4'h0;
      transfer_end     <= (nxt_state == S_DONE) &&
                          (state_ff != S_DONE);
      bus_error_status <= 1'b0;
      byte_access      <= take ? (req.len == `SSMS_LEN_B1) :
                          (byte_access && nxt_state != S_IDLE);
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_sync_n);

  a_phase_period: assert property (
    $rose(clk_out.phase_first) |-> ##4 $rose(clk_out.phase_first))
    else $error("First phase period not four cycles");
  a_phase_quad: assert property (
    $changed(clk_out.phase_first) |=> $changed(clk_out.phase_second)
      ##1 $stable(clk_out.phase_second))
    else $error("Second phase not a quarter period behind");
  a_tick_slow: assert property (
    $changed(clk_out.tick) |=> $stable(clk_out.tick) [*8])
    else $error("Timer tick toggles too fast");
  a_grant_onehot: assert property (
    $onehot0(~bus_grant_n))
    else $error("More than one grant active");
  a_grant_prio: assert property (
    (bus_grant_n == `SSMS_GRANT_NONE && !req_sync_ff[3]) |=>
      !bus_grant_n[3])
    else $error("Highest request not granted");
  a_grant_hold: assert property (
    (state_ff != S_IDLE) |=> $stable(bus_grant_n))
    else $error("Grant changed during access");
  a_len_load: assert property (
    take |=> cnt_ff == recode($past(req.len)))
    else $error("Length counter loaded wrong");
  a_byte_flag: assert property (
    (take && req.len == `SSMS_LEN_B1) |=> byte_access)
    else $error("Single byte signal missing");
  a_end_pulse: assert property (
    (state_ff == S_DONE) |-> transfer_end && !bus_error_status)
    else $error("Transfer end missing or error set");
  a_wait_once: assert property (
    wait_insert |-> state_ff == S_WAIT ##1 !wait_insert)
    else $error("Wait insert not single");
  a_wait_ics: assert property (
    (state_ff == S_WAIT) |-> interconnect_status == ~bus_grant_n)
    else $error("Wait not shown on status pin");
  a_no_wait: assert property (
    (state_ff == S_ACCESS && !unaligned) |=> state_ff != S_WAIT)
    else $error("Wait state on aligned access");
  a_swap_read: assert property (
    (xfer && !wr_ff && unaligned) |->
      rd_word[7:0] == bank_odd[idx])
    else $error("Unaligned read not right-justified");

  c_unaligned: cover property (state_ff == S_WAIT ##1 xfer);
  c_multi: cover property (take && req.len == `SSMS_LEN_B10);
  c_contend: cover property (req_sync_ff == 4'h0);
endmodule : ssms_top

//--- test/ssms_proc_model.sv
// Behavioural model of the four processors on the request pins.
// Assumes start pulses from the bench and grants on clk_sys.
`timescale 1ns/1ns
module ssms_proc_model (
  input  wire logic       clk_sys,       // System clock
  input  wire logic       rst_n,         // Async reset
  input  wire logic [3:0] start,         // Begin a request
  input  wire logic [3:0] bus_grant_n,   // Grants
  input  wire logic       transfer_end,  // End pulse
  output logic      [3:0] bus_request_n  // Requests
);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bus_request_n <= 4'hf;
    end else begin
      for (int i = 0; i < 4; i++) begin
        // Held through the access, never withdrawn early
        if (!bus_grant_n[i] && transfer_end) begin
          bus_request_n[i] <= 1'b1;
        end else if (start[i]) begin
          bus_request_n[i] <= 1'b0;
        end
      end
    end
  end
endmodule : ssms_proc_model

//--- test/tb_top.sv
// Self-checking bench for the shared static memory system.
// Assumes the design files and ssms_proc_model are compiled first.
`timescale 1ns/1ns
module tb_top;
  import ssms_pkg::*;
  logic        clk_sys     = 1'b0;
  logic        rst_n       = 1'b0;
  logic [3:0]  start       = 4'h0;
  logic        req_valid   = 1'b0;
  ssms_req_t   req         = '0;
  logic        wdata_valid = 1'b0;
  logic [15:0] wdata       = 16'h0000;
  logic        rd_ready    = 1'b0;
  logic        hold_rd     = 1'b1;
  logic        ba_seen     = 1'b0;
  logic [3:0]  bus_request_n, bus_grant_n, interconnect_status;
  ssms_clk_t   clk_out;
  logic        req_ready, wdata_ready, rd_valid, bus_error_status;
  logic        transfer_end, byte_access, wait_insert;
  logic [15:0] rd_data;
  logic [7:0]  mem [512];
  logic [15:0] exp_q [$];
  int          mismatches  = 0;
  int          cmp_count   = 0;
  int          wi_cnt      = 0;
  int          te_cnt      = 0;

  always #5 clk_sys = ~clk_sys;

  ssms_top dut (.clk_sys, .rst_n, .bus_request_n, .bus_grant_n, .clk_out,
    .req_valid, .req, .req_ready, .wdata_valid, .wdata, .wdata_ready,
    .rd_valid, .rd_data, .rd_ready, .interconnect_status,
    .bus_error_status, .transfer_end, .byte_access, .wait_insert);

  ssms_proc_model procs (.clk_sys, .rst_n, .start, .bus_grant_n,
    .transfer_end, .bus_request_n);

  // Random drain stalls keep the read FIFO under pressure
  always @(posedge clk_sys) rd_ready <= !hold_rd && ($urandom % 4 != 0);

  task automatic check(string nm, logic [31:0] exp, logic [31:0] got);
    cmp_count++;
    if (got !== exp || $isunknown(got)) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  always @(posedge clk_sys) begin
    if (wait_insert === 1'b1) begin
      wi_cnt++;
      check("wait_status", 4'hf, interconnect_status ^ bus_grant_n);
    end
    if (transfer_end === 1'b1) begin
      te_cnt++;
      check("error_status", 0, bus_error_status);
    end
    if (byte_access === 1'b1) ba_seen = 1'b1;
    if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
      if (exp_q.size() == 0) check("rd_extra", 0, 1);
      else check("rd_data", exp_q.pop_front(), rd_data);
    end
  end

  task automatic wait_sig(string nm, ref logic s);
    int k;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (s !== 1'b1 && k < 300);
    if (s !== 1'b1) check(nm, 1, 0);
  endtask : wait_sig

  task automatic xfer(int p, logic go, logic w, logic [2:0] l,
                      logic [15:0] a, logic [3:0] late);
    int          n, k, w0;
    logic [8:0]  b;
    logic [15:0] d;
    logic [3:0]  g;
    n = (l == 3'h0) ? 1 : (l == 3'h4) ? 5 : (1 << (l - 1));
    g = ~(4'h1 << p);
    if (go) begin
      start <= 4'h1 << p;
      @(posedge clk_sys);
      start <= 4'h0;
    end
    k = 0;
    while (bus_grant_n === 4'hf && k < 50) begin
      @(posedge clk_sys);
      k++;
    end
    check("grant", g, bus_grant_n);
    req_valid <= 1'b1;
    req <= '{wr: w, len: l, addr: a};
    wait_sig("req_ready", req_ready);
    req_valid <= 1'b0;
    start <= late;
    w0 = wi_cnt;
    ba_seen = 1'b0;
    for (int i = 0; i < n; i++) begin
      b = a[8:0] + 9'(2 * i);
      if (w) begin
        d = 16'($urandom);
        mem[b] = d[7:0];
        if (l != 3'h0) mem[b + 9'h1] = d[15:8];
        wdata_valid <= 1'b1;
        wdata <= d;
        wait_sig("wdata_ready", wdata_ready);
      end else begin
        exp_q.push_back({(l == 3'h0) ? 8'h00 : mem[b + 9'h1], mem[b]});
      end
    end
    wdata_valid <= 1'b0;
    wait_sig("transfer_end", transfer_end);
    start <= 4'h0;
    check("grant_held", g, bus_grant_n);
    check("waits", (a[0] && l != 3'h0) ? n : 0, wi_cnt - w0);
    check("byte_access", l == 3'h0, ba_seen);
    k = 0;
    while (bus_grant_n !== 4'hf && k < 20) begin
      @(posedge clk_sys);
      k++;
    end
  endtask : xfer

  task automatic clk_test();
    int        rf[$], rs[$], ff[$], tk[$];
    ssms_clk_t pv;
    pv = clk_out;
    for (int t = 0; t < 4200; t++) begin
      @(posedge clk_sys);
      if (clk_out.phase_first && !pv.phase_first) rf.push_back(t);
      if (!clk_out.phase_first && pv.phase_first) ff.push_back(t);
      if (clk_out.phase_second && !pv.phase_second) rs.push_back(t);
      if (clk_out.tick !== pv.tick) tk.push_back(t);
      pv = clk_out;
    end
    check("phase_period", 4, rf[1] - rf[0]);
    check("phase_high", 2, (ff[1] - rf[0]) % 4);
    check("phase_lag", 1, (rs[1] - rf[0]) % 4);
    check("tick_half", 2048, tk[1] - tk[0]);
  endtask : clk_test

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    #500000;
    mismatches++;
    tally_and_finish();
  end

  initial begin
    int k;
    void'($urandom(32'had0805e2));
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    clk_test();
    $display("test clocks done");
    hold_rd <= 1'b0;
    // Each length code, aligned and unaligned, upper bits random
    for (int l = 0; l < 5; l++) begin
      for (int u = 0; u < 2; u++) begin
        logic [15:0] a;
        a = {7'($urandom), 9'(64 * l + u)};
        xfer(l % 4, 1, 1, 3'(l), a, 4'h0);
        xfer(3 - l % 4, 1, 0, 3'(l), a, 4'h0);
      end
    end
    $display("test lengths done");
    start <= 4'hf;
    @(posedge clk_sys);
    start <= 4'h0;
    for (int p = 3; p >= 0; p--) xfer(p, 0, 0, 3'h1, 16'h0040, 4'h0);
    $display("test priority done");
    // Late high-priority request must not cut in
    xfer(0, 1, 0, 3'h3, 16'h00c0, 4'h8);
    xfer(3, 0, 0, 3'h0, 16'h00c0, 4'h0);
    $display("test no preemption done");
    hold_rd <= 1'b1;
    repeat (6) xfer(1, 1, 0, 3'h4, 16'h0100, 4'h0);
    check("fifo_holding", 1, rd_valid);
    fork
      xfer(2, 1, 0, 3'h4, 16'h0100, 4'h0);
      begin
        k = te_cnt;
        repeat (60) @(posedge clk_sys);
        check("stalled_end", k, te_cnt);
        hold_rd <= 1'b0;
      end
    join
    repeat (100) @(posedge clk_sys);
    check("drained", 0, exp_q.size());
    $display("test fifo fill done");
    tally_and_finish();
  end
endmodule : tb_top
